// File: core/dram_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - Page mode: consecutive same-row requests reuse the open row, any column, except a write whose mask differs from the latched one.
// - Write-select low at row fall latches a per-quadrant mask from data pins.
// - Controller holds address stable before each column strobe falls; the row address changes on the same edge as row fall.
// - Refresh all 1024 rows within sixteen milliseconds; code spaces refreshes 1563 cycles apart, about 16.005 ms.
// - Row-only refresh: row address given, column strobe kept high.
// - Hidden refresh keeps read data; this controller does not issue it.
// - Column-before-row refresh: column strobe falls first, held past row fall.
// - Wait 200 us after power-up then eight refresh cycles.
module dram_ctrl import dram_ctrl_pkg::*; #(
    parameter int POWERUP_CYCLES = POWERUP_CYC,
    parameter int REFRESH_CYCLES = REFRESH_INTERVAL_CYC
) (
    input wire logic core_clk, // System clock
    input wire logic rst, // Synchronous reset
    input wire logic req_valid, // Request present
    output logic req_ready, // Request taken this cycle
    input wire logic [1:0] req_op, // dram_op_t code
    input wire logic [WORD_ADDR_W-1:0] req_addr, // Word address
    input wire logic [DATA_W-1:0] req_wdata, // Write data
    input wire logic [DATA_W-1:0] req_mask, // Quadrant write enables, 1 writes
    output logic rsp_valid, // Read data valid pulse
    output logic [DATA_W-1:0] rsp_rdata, // Read data
    output logic init_done, // Initialisation complete
    output logic test_mode, // Device is in test mode
    output logic ras_n, // Row strobe
    output logic cas_n, // Column strobe
    output logic oe_n, // Output enable
    output logic mask_or_write_select_n, // Write-select / mask enable
    output logic [ADDR_W-1:0] muxed_addr_in, // Multiplexed address
    output logic [DATA_W-1:0] mask_data_io_o, // Data/mask out
    output logic mask_data_io_oe, // Data/mask drive enable
    input wire logic [DATA_W-1:0] mask_data_io_i // Data in
);
    initial begin
        if (POWERUP_CYCLES >= 2**CNT_W || REFRESH_CYCLES >= 2**CNT_W || REFRESH_CYCLES < 16)
            $error("dram_ctrl timing parameters out of range");
    end

    dram_state_t state_ff, nxt_state;
    logic ras_n_ff, nxt_ras_n, cas_n_ff, nxt_cas_n, oe_n_ff, nxt_oe_n;
    logic we_n_ff, nxt_we_n, dq_oe_ff, nxt_dq_oe;
    logic [ADDR_W-1:0] addr_ff, nxt_addr;
    logic [DATA_W-1:0] dq_ff, nxt_dq, rdata_ff, nxt_rdata;
    logic rvalid_ff, nxt_rvalid, test_ff, nxt_test, init_ff, nxt_init;
    logic [ADDR_W-1:0] row_ff, nxt_row, rrow_ff, nxt_rrow;
    logic row_valid_ff, nxt_row_valid, is_write_ff, nxt_is_write;
    logic [ADDR_W-1:0] col_ff, nxt_col;
    logic [DATA_W-1:0] wdata_ff, nxt_wdata;
    logic [3:0] init_cnt_ff, nxt_init_cnt;
    logic ref_pend_ff, nxt_ref_pend, pu_armed_ff;
    logic [DATA_W-1:0] rmask_ff, nxt_rmask;
    logic tmr_load, tmr_done, ref_done;
    logic [CNT_W-1:0] tmr_val;
    logic [ADDR_W-1:0] req_row, req_col;
    logic take;

    assign req_row = req_addr[WORD_ADDR_W-1:ADDR_W];
    assign req_col = req_addr[ADDR_W-1:0];

    cycle_timer #(.WIDTH(CNT_W)) u_step (
        .core_clk(core_clk),
        .rst(rst),
        .load(tmr_load),
        .load_val(tmr_val),
        .done(tmr_done)
    );

    // Refresh interval timer; reloads itself when it expires
    cycle_timer #(.WIDTH(CNT_W)) u_refresh (
        .core_clk(core_clk),
        .rst(rst),
        .load(ref_done),
        .load_val(CNT_W'(REFRESH_CYCLES)),
        .done(ref_done)
    );

    always_comb begin
        nxt_state = state_ff;
        nxt_ras_n = ras_n_ff;
        nxt_cas_n = cas_n_ff;
        nxt_oe_n = oe_n_ff;
        nxt_we_n = we_n_ff;
        nxt_dq_oe = dq_oe_ff;
        nxt_addr = addr_ff;
        nxt_dq = dq_ff;
        nxt_rdata = rdata_ff;
        nxt_rvalid = 1'b0;
        nxt_test = test_ff;
        nxt_init = init_ff;
        nxt_row = row_ff;
        nxt_rrow = rrow_ff;
        nxt_row_valid = row_valid_ff;
        nxt_is_write = is_write_ff;
        nxt_col = col_ff;
        nxt_wdata = wdata_ff;
        nxt_init_cnt = init_cnt_ff;
        nxt_ref_pend = ref_pend_ff | ref_done;
        nxt_rmask = rmask_ff;
        tmr_load = 1'b0;
        tmr_val = '0;
        take = 1'b0;
        unique case (state_ff)
            ST_POWERUP: begin
                if (!pu_armed_ff) begin
                    // First cycle after reset starts the power-up pause
                    tmr_load = 1'b1;
                    tmr_val = CNT_W'(POWERUP_CYCLES);
                end else if (tmr_done) begin
                    nxt_state = ST_PRECHARGE;
                    tmr_load = 1'b1;
                    tmr_val = CNT_W'(PRECHARGE_CYC);
                end
            end
            ST_IDLE, ST_ROW_OPEN: begin
                if (ref_pend_ff || !init_ff) begin
                    if (state_ff == ST_ROW_OPEN) begin
                        nxt_ras_n = 1'b1;
                        nxt_row_valid = 1'b0;
                        nxt_dq_oe = 1'b0;
                        nxt_state = ST_PRECHARGE;
                        tmr_load = 1'b1;
                        tmr_val = CNT_W'(PRECHARGE_CYC);
                    end else begin
                        // Column-before-row refresh; hidden refresh is never issued
                        nxt_cas_n = 1'b0;
                        nxt_we_n = 1'b1;
                        nxt_ref_pend = ref_done;
                        nxt_state = ST_CBR_SETUP;
                        tmr_load = 1'b1;
                        tmr_val = CNT_W'(ROW_SETUP_CYC);
                    end
                end else if (req_valid) begin
                    if (req_op == OP_TEST_ENTRY || req_op == OP_TEST_EXIT) begin
                        if (state_ff == ST_ROW_OPEN) begin
                            nxt_ras_n = 1'b1;
                            nxt_row_valid = 1'b0;
                            nxt_dq_oe = 1'b0;
                            nxt_state = ST_PRECHARGE;
                            tmr_load = 1'b1;
                            tmr_val = CNT_W'(PRECHARGE_CYC);
                        end else if (req_op == OP_TEST_ENTRY) begin
                            take = 1'b1;
                            nxt_cas_n = 1'b0;
                            nxt_we_n = 1'b0;
                            nxt_test = 1'b1;
                            nxt_state = ST_CBR_SETUP;
                            tmr_load = 1'b1;
                            tmr_val = CNT_W'(ROW_SETUP_CYC);
                        end else begin
                            take = 1'b1;
                            nxt_addr = rrow_ff;
                            nxt_ras_n = 1'b0;
                            nxt_rrow = rrow_ff + ADDR_W'(1);
                            nxt_test = 1'b0;
                            nxt_state = ST_RONLY_ACTIVE;
                            tmr_load = 1'b1;
                            tmr_val = CNT_W'(ACTIVE_CYC);
                        end
                    end else if (state_ff == ST_ROW_OPEN && row_valid_ff && req_row == row_ff
                                 && (req_op != OP_WRITE || req_mask == rmask_ff)) begin
                        take = 1'b1;
                        nxt_col = test_ff ? (req_col & ~ADDR_W'(1)) : req_col;
                        nxt_addr = nxt_col;
                        nxt_is_write = (req_op == OP_WRITE);
                        nxt_we_n = (req_op != OP_WRITE);
                        nxt_wdata = req_wdata;
                        nxt_dq = req_wdata;
                        nxt_dq_oe = (req_op == OP_WRITE);
                        nxt_state = ST_COL_ACCESS;
                        tmr_load = 1'b1;
                        tmr_val = CNT_W'(ROW_SETUP_CYC);
                    end else if (state_ff == ST_ROW_OPEN) begin
                        nxt_ras_n = 1'b1;
                        nxt_row_valid = 1'b0;
                        nxt_dq_oe = 1'b0;
                        nxt_state = ST_PRECHARGE;
                        tmr_load = 1'b1;
                        tmr_val = CNT_W'(PRECHARGE_CYC);
                    end else begin
                        // Open the row; mask sampled at row strobe fall
                        take = 1'b1;
                        nxt_row = req_row;
                        nxt_addr = req_row;
                        nxt_ras_n = 1'b0;
                        nxt_row_valid = 1'b1;
                        // Mask stays latched for the row; a different write mask reopens it
                        nxt_rmask = (req_op == OP_WRITE) ? req_mask : MASK_ALL_WRITE;
                        nxt_is_write = (req_op == OP_WRITE);
                        nxt_col = test_ff ? (req_col & ~ADDR_W'(1)) : req_col;
                        nxt_wdata = req_wdata;
                        // Masked write only when some quadrant is blocked
                        nxt_we_n = !((req_op == OP_WRITE) && (req_mask != MASK_ALL_WRITE));
                        nxt_dq = req_mask;
                        nxt_dq_oe = 1'b1;
                        nxt_state = ST_ROW_SETUP;
                        tmr_load = 1'b1;
                        tmr_val = CNT_W'(ROW_SETUP_CYC);
                    end
                end
            end
            ST_ROW_SETUP: begin
                // Mask held on pins for one cycle after row strobe fall, then column address
                nxt_addr = col_ff;
                nxt_we_n = !is_write_ff;
                nxt_dq = wdata_ff;
                nxt_dq_oe = is_write_ff;
                nxt_state = ST_COL_ACCESS;
                tmr_load = 1'b1;
                tmr_val = CNT_W'(ROW_SETUP_CYC);
            end
            ST_COL_ACCESS: begin
                if (cas_n_ff && tmr_done) begin
                    nxt_cas_n = 1'b0;
                    nxt_oe_n = is_write_ff;
                    tmr_load = 1'b1;
                    tmr_val = CNT_W'(COL_ACCESS_CYC);
                end else if (!cas_n_ff && tmr_done) begin
                    if (!is_write_ff) begin
                        nxt_rdata = mask_data_io_i;
                        nxt_rvalid = 1'b1;
                    end
                    nxt_cas_n = 1'b1;
                    nxt_oe_n = 1'b1;
                    nxt_we_n = 1'b1;
                    nxt_dq_oe = 1'b0;
                    nxt_state = ST_COL_HIGH;
                    tmr_load = 1'b1;
                    tmr_val = CNT_W'(COL_HIGH_CYC);
                end
            end
            ST_COL_HIGH: begin
                if (tmr_done) begin
                    nxt_state = ST_ROW_OPEN;
                end
            end
            ST_PRECHARGE: begin
                if (tmr_done) begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_CBR_SETUP: begin
                if (tmr_done) begin
                    nxt_ras_n = 1'b0;
                    nxt_state = ST_CBR_ACTIVE;
                    tmr_load = 1'b1;
                    tmr_val = CNT_W'(ACTIVE_CYC);
                end
            end
            ST_CBR_ACTIVE, ST_RONLY_ACTIVE: begin
                if (tmr_done) begin
                    nxt_ras_n = 1'b1;
                    nxt_cas_n = 1'b1;
                    if (state_ff == ST_CBR_ACTIVE && !we_n_ff) begin
                        nxt_we_n = 1'b1;
                    end else begin
                        nxt_test = 1'b0;
                    end
                    if (!init_ff) begin
                        nxt_init_cnt = init_cnt_ff + 4'h1;
                        nxt_init = (init_cnt_ff == 4'(INIT_CYCLES - 1));
                    end
                    nxt_state = ST_PRECHARGE;
                    tmr_load = 1'b1;
                    tmr_val = CNT_W'(PRECHARGE_CYC);
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_ff <= ST_POWERUP;
            ras_n_ff <= 1'b1;
            cas_n_ff <= 1'b1;
            oe_n_ff <= 1'b1;
            we_n_ff <= 1'b1;
            dq_oe_ff <= 1'b0;
            addr_ff <= '0;
            dq_ff <= '0;
            rdata_ff <= '0;
            rvalid_ff <= 1'b0;
            test_ff <= 1'b0;
            init_ff <= 1'b0;
            row_ff <= '0;
            rrow_ff <= '0;
            row_valid_ff <= 1'b0;
            is_write_ff <= 1'b0;
            col_ff <= '0;
            wdata_ff <= '0;
            init_cnt_ff <= '0;
            ref_pend_ff <= 1'b0;
            rmask_ff <= MASK_ALL_WRITE;
        end else begin
            state_ff <= nxt_state;
            ras_n_ff <= nxt_ras_n;
            cas_n_ff <= nxt_cas_n;
            oe_n_ff <= nxt_oe_n;
            we_n_ff <= nxt_we_n;
            dq_oe_ff <= nxt_dq_oe;
            addr_ff <= nxt_addr;
            dq_ff <= nxt_dq;
            rdata_ff <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
            test_ff <= nxt_test;
            init_ff <= nxt_init;
            row_ff <= nxt_row;
            rrow_ff <= nxt_rrow;
            row_valid_ff <= nxt_row_valid;
            is_write_ff <= nxt_is_write;
            col_ff <= nxt_col;
            wdata_ff <= nxt_wdata;
            init_cnt_ff <= nxt_init_cnt;
            ref_pend_ff <= nxt_ref_pend;
            rmask_ff <= nxt_rmask;
        end
    end

    // Power-up wait loads on the first cycle after reset via a one-shot
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pu_armed_ff <= 1'b0;
        end else begin
            pu_armed_ff <= 1'b1;
        end
    end

    assign req_ready = take;
    assign rsp_valid = rvalid_ff;
    assign rsp_rdata = rdata_ff;
    assign init_done = init_ff;
    assign test_mode = test_ff;
    assign ras_n = ras_n_ff;
    assign cas_n = cas_n_ff;
    assign oe_n = oe_n_ff;
    assign mask_or_write_select_n = we_n_ff;
    assign muxed_addr_in = addr_ff;
    assign mask_data_io_o = dq_ff;
    assign mask_data_io_oe = dq_oe_ff;
endmodule
`default_nettype wire

// File: core/dram_ctrl_pkg.sv
package dram_ctrl_pkg;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 4;
    localparam int WORD_ADDR_W = 2 * ADDR_W;
    localparam int ROWS = 1024;
    // Clock period and pin timing, ns; power-up in us, refresh period in ms, init in refresh cycles
    localparam int CLK_PERIOD_NS = 10;
    localparam int POWERUP_US = 200;
    localparam int REFRESH_PERIOD_MS = 16;
    localparam int INIT_CYCLES = 8;
    localparam int T_ROW_SETUP_NS = 20;
    localparam int T_ACTIVE_NS = 60;
    localparam int T_PRECHARGE_NS = 40;
    localparam int T_COL_ACCESS_NS = 35;
    localparam int T_COL_HIGH_NS = 10;
    // Least times round up to whole cycles
    localparam int ROW_SETUP_CYC = (T_ROW_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACTIVE_CYC = (T_ACTIVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PRECHARGE_CYC = (T_PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int COL_ACCESS_CYC = (T_COL_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int COL_HIGH_CYC = (T_COL_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int POWERUP_CYC = POWERUP_US * 1000 / CLK_PERIOD_NS;
    // Longest time rounds down; one refresh slot per row
    localparam int REFRESH_INTERVAL_CYC =
        REFRESH_PERIOD_MS * 1000000 / CLK_PERIOD_NS / ROWS;
    localparam int CNT_W = 16;
    localparam logic [DATA_W-1:0] MASK_ALL_WRITE = 4'hf;

    typedef enum logic [3:0] {
        ST_POWERUP = 4'h0,
        ST_IDLE = 4'h1,
        ST_ROW_SETUP = 4'h2,
        ST_ROW_OPEN = 4'h3,
        ST_COL_ACCESS = 4'h4,
        ST_COL_HIGH = 4'h5,
        ST_PRECHARGE = 4'h6,
        ST_CBR_SETUP = 4'h7,
        ST_CBR_ACTIVE = 4'h8,
        ST_RONLY_ACTIVE = 4'h9
    } dram_state_t;

    typedef enum logic [1:0] {
        OP_READ = 2'h0,
        OP_WRITE = 2'h1,
        OP_TEST_ENTRY = 2'h2,
        OP_TEST_EXIT = 2'h3
    } dram_op_t;
endpackage

// File: core/cycle_timer.sv
`timescale 1ns/1ns
`default_nettype none
// Loadable down-counter; done is high while the count is zero
module cycle_timer import dram_ctrl_pkg::*; #(
    parameter int WIDTH = CNT_W
) (
    input wire logic core_clk, // System clock
    input wire logic rst, // Synchronous reset
    input wire logic load, // Load a new count
    input wire logic [WIDTH-1:0] load_val, // Count to load
    output logic done // Count has reached zero
);
    logic [WIDTH-1:0] cnt_ff;
    logic [WIDTH-1:0] nxt_cnt;

    initial begin
        if (WIDTH < 2) $error("cycle_timer WIDTH too small");
    end

    always_comb begin
        nxt_cnt = cnt_ff;
        if (load) begin
            nxt_cnt = load_val;
        end else if (cnt_ff != '0) begin
            nxt_cnt = cnt_ff - WIDTH'(1);
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    assign done = (cnt_ff == '0);
endmodule
`default_nettype wire

// File: tb/dram_ctrl_chk.sv
`timescale 1ns/1ns
`default_nettype none
module dram_ctrl_chk import dram_ctrl_pkg::*; (
    input wire logic core_clk, // Clock
    input wire logic rst, // Reset
    input wire logic req_valid, // Request present
    input wire logic req_ready, // Request taken
    input wire logic [1:0] req_op, // Operation code
    input wire logic rsp_valid, // Read data valid
    input wire logic init_done, // Init complete
    input wire logic ras_n, // Row strobe
    input wire logic cas_n, // Column strobe
    input wire logic oe_n, // Output enable
    input wire logic mask_or_write_select_n, // Write select
    input wire logic [ADDR_W-1:0] muxed_addr_in, // Address pins
    input wire logic mask_data_io_oe // Data drive enable
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence seq_read_take;
        req_valid && req_ready && req_op == 2'h0;
    endsequence
    sequence seq_cbr_start;
        $fell(ras_n) && !cas_n;
    endsequence
    sequence seq_col_fall;
        $fell(cas_n) && !ras_n;
    endsequence
    chk_read_answer: assert property (seq_read_take |-> ##[4:30] rsp_valid)
        else $error("read answer missing");
    chk_cbr_order: assert property (seq_cbr_start |-> !$past(cas_n))
        else $error("column strobe not low before row strobe");
    chk_cbr_hold: assert property (seq_cbr_start |=> !cas_n)
        else $error("column strobe released at row fall");
    chk_col_addr_stable: assert property (seq_col_fall |-> $stable(muxed_addr_in))
        else $error("address moved at column strobe fall");
    chk_early_write: assert property (seq_col_fall ##0 !mask_or_write_select_n
        |-> !$past(mask_or_write_select_n) && oe_n)
        else $error("write select not early or output enable low");
    chk_mask_driven: assert property ($fell(ras_n) && cas_n && !mask_or_write_select_n
        |-> mask_data_io_oe)
        else $error("mask not driven at row fall");
    chk_wdata_driven: assert property (seq_col_fall ##0 !mask_or_write_select_n
        |-> mask_data_io_oe)
        else $error("write data not driven");
    chk_read_no_fight: assert property (!oe_n |-> mask_or_write_select_n && !mask_data_io_oe)
        else $error("output enable during write or own drive");
    chk_ras_precharge: assert property ($rose(ras_n) |-> ras_n [*3])
        else $error("precharge too short");
    chk_init_gate: assert property (req_ready |-> init_done)
        else $error("request taken before init");
    chk_oe_in_col: assert property (!oe_n |-> !ras_n && !cas_n)
        else $error("output enable low outside a column cycle");
endmodule
bind dram_ctrl dram_ctrl_chk chk_i (
    .core_clk(core_clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
    .req_op(req_op), .rsp_valid(rsp_valid), .init_done(init_done), .ras_n(ras_n),
    .cas_n(cas_n), .oe_n(oe_n), .mask_or_write_select_n(mask_or_write_select_n),
    .muxed_addr_in(muxed_addr_in), .mask_data_io_oe(mask_data_io_oe)
);
`default_nettype wire

// File: tb/dram_dev_model.sv
`timescale 1ns/1ns
`default_nettype none
// Strobes are sampled on the clock; the controller registers them, so edges are exact
module dram_dev_model import dram_ctrl_pkg::*; #(
    parameter int ACC_CYC = 2
) (
    input wire logic core_clk, // Sampling clock
    input wire logic ras_n, // Row strobe
    input wire logic cas_n, // Column strobe
    input wire logic oe_n, // Output enable
    input wire logic we_n, // Write select
    input wire logic [ADDR_W-1:0] addr, // Multiplexed address
    input wire logic [DATA_W-1:0] dq_in, // Resolved data pins
    output logic [DATA_W-1:0] dq_out, // Data driven
    output logic dq_en // Driving the pins
);
    logic [DATA_W-1:0] mem [int];
    logic [DATA_W-1:0] wmask = '0;
    logic [DATA_W-1:0] rd = '0;
    logic [ADDR_W-1:0] row = '0;
    logic ras_q = 1'b1, cas_q = 1'b1, open = 1'b0, had_col = 1'b0;
    logic tmode = 1'b0, rd_cyc = 1'b0;
    int acc = 0;
    int a;
    always @(posedge core_clk) begin
        acc <= acc + 1;
        ras_q <= ras_n;
        cas_q <= cas_n;
        if (ras_q && !ras_n && !cas_n) begin
            tmode <= !we_n;
        end else if (ras_q && !ras_n) begin
            row <= addr;
            open <= 1'b1;
            had_col <= 1'b0;
            wmask <= we_n ? MASK_ALL_WRITE : dq_in;
        end
        if (!ras_q && ras_n) begin
            open <= 1'b0;
            if (open && !had_col) tmode <= 1'b0;
        end
        if (cas_q && !cas_n && open && !ras_n) begin
            a = int'({row, addr});
            had_col <= 1'b1;
            rd_cyc <= we_n;
            acc <= 0;
            if (!we_n && tmode) begin
                mem[a & ~1] = {DATA_W{dq_in[0]}};
                mem[a | 1] = {DATA_W{dq_in[0]}};
            end else if (!we_n) begin
                mem[a] = (mem[a] & ~wmask) | (dq_in & wmask);
            end else if (tmode) begin
                rd <= ({mem[a & ~1], mem[a | 1]} == {8{mem[a & ~1][0]}}) ? 4'hf : 4'h0;
            end else begin
                rd <= mem[a];
            end
        end
    end
    // Early writes never drive; reads drive only with all three strobes low
    assign dq_en = open && rd_cyc && !ras_n && !cas_n && !oe_n;
    // Before the access time the pins carry garbage, not the coming value
    assign dq_out = (acc >= ACC_CYC) ? rd : ~rd;
endmodule
`default_nettype wire

// File: tb/dram_1mx4_write_mask_interface_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module dram_1mx4_write_mask_interface_tb_top import dram_ctrl_pkg::*;;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    logic [1:0] req_op = 2'h0;
    logic [WORD_ADDR_W-1:0] req_addr = '0;
    logic [DATA_W-1:0] req_wdata = '0;
    logic [DATA_W-1:0] req_mask = '0;
    logic req_ready, rsp_valid, init_done, test_mode, ras_n, cas_n, oe_n, we_n, dq_oe, dev_en;
    logic [ADDR_W-1:0] ma;
    logic [DATA_W-1:0] rsp_rdata, dq_o, dq_i, dev_q;
    logic [DATA_W-1:0] dq_last = '0;
    logic [31:0] seed = 32'hc631;
    logic [DATA_W-1:0] exp_mem [int];
    logic [WORD_ADDR_W-1:0] addrs [$];
    logic tm = 1'b0;
    int n_mismatch = 0;
    int checked = 0;

    always #5 core_clk = ~core_clk;

    dram_ctrl #(.POWERUP_CYCLES(20), .REFRESH_CYCLES(200)) dut (
        .core_clk(core_clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
        .req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata), .req_mask(req_mask),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .init_done(init_done),
        .test_mode(test_mode), .ras_n(ras_n), .cas_n(cas_n), .oe_n(oe_n),
        .mask_or_write_select_n(we_n), .muxed_addr_in(ma), .mask_data_io_o(dq_o),
        .mask_data_io_oe(dq_oe), .mask_data_io_i(dq_i)
    );
    dram_dev_model dev (
        .core_clk(core_clk), .ras_n(ras_n), .cas_n(cas_n), .oe_n(oe_n), .we_n(we_n),
        .addr(ma), .dq_in(dq_i), .dq_out(dev_q), .dq_en(dev_en)
    );

    // Undriven pins flip every cycle so a stale value never passes as data
    always_comb begin
        if (dq_oe) dq_i = dq_o;
        else if (dev_en) dq_i = dev_q;
        else dq_i = ~dq_last;
    end
    always @(posedge core_clk) dq_last <= dq_i;

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic do_req(input logic [1:0] op, input logic [WORD_ADDR_W-1:0] a,
            input logic [DATA_W-1:0] d, input logic [DATA_W-1:0] m,
            output logic [DATA_W-1:0] rd);
        int i;
        @(posedge core_clk);
        #1;
        req_op = op;
        req_addr = a;
        req_wdata = d;
        req_mask = m;
        req_valid = 1'b1;
        i = 0;
        do begin @(negedge core_clk); i++; end while (req_ready !== 1'b1 && i < 400);
        @(posedge core_clk);
        #1;
        req_valid = 1'b0;
        if (i >= 400) n_mismatch++;
        rd = 'x;
        if (op == OP_READ) begin
            i = 0;
            do begin @(negedge core_clk); i++; end while (rsp_valid !== 1'b1 && i < 60);
            rd = rsp_rdata;
            if (i >= 60) n_mismatch++;
        end
    endtask

    task automatic wr(input logic [WORD_ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
            input logic [DATA_W-1:0] m);
        logic [DATA_W-1:0] rd;
        do_req(OP_WRITE, a, d, m, rd);
        if (tm) begin
            exp_mem[{a[WORD_ADDR_W-1:1], 1'b0}] = {DATA_W{d[0]}};
            exp_mem[{a[WORD_ADDR_W-1:1], 1'b1}] = {DATA_W{d[0]}};
        end else begin
            exp_mem[a] = exp_mem.exists(a) ? (exp_mem[a] & ~m) | (d & m) : d;
        end
    endtask

    task automatic rd_chk(input logic [WORD_ADDR_W-1:0] a);
        logic [DATA_W-1:0] rd, lo, hi, ex;
        do_req(OP_READ, a, '0, '0, rd);
        if (tm) begin
            lo = exp_mem[{a[WORD_ADDR_W-1:1], 1'b0}];
            hi = exp_mem[{a[WORD_ADDR_W-1:1], 1'b1}];
            ex = ({lo, hi} == {8{lo[0]}}) ? 4'hf : 4'h0;
        end else begin
            ex = exp_mem[a];
        end
        check(rd, ex);
    endtask

    task automatic wait_tm(input logic v);
        int i;
        for (i = 0; i < 100 && test_mode !== v; i++) @(negedge core_clk);
        check(test_mode, v);
    endtask

    initial begin
        logic [DATA_W-1:0] rd;
        int i;
        repeat (4) @(posedge core_clk);
        #1;
        rst = 1'b0;
        i = 0;
        // Strobes must rest through the power-up pause
        repeat (19) begin
            @(negedge core_clk);
            if (ras_n !== 1'b1 || cas_n !== 1'b1) i++;
        end
        check(i, 0);
        i = 0;
        do begin @(negedge core_clk); i++; end while (init_done !== 1'b1 && i < 2000);
        check(init_done, 1'b1);
        check(test_mode, 1'b0);
        addrs = '{20'h00000, 20'h003ff, 20'hffc00, 20'hfffff, 20'hffc01, 20'h00001};
        repeat (6) addrs.push_back(WORD_ADDR_W'(xs()));
        foreach (addrs[k]) wr(addrs[k], DATA_W'(xs()), MASK_ALL_WRITE);
        foreach (addrs[k]) rd_chk(addrs[k]);
        for (int k = 0; k < 16; k++) begin
            wr(addrs[k % 6], DATA_W'(xs()), DATA_W'(k));
            rd_chk(addrs[k % 6]);
        end
        wr(20'h00010, 4'h5, MASK_ALL_WRITE);
        wr(20'h00011, 4'ha, MASK_ALL_WRITE);
        // Wait until both strobes are low, first seen in the column cycle of the write to 20'h00011, then enter test mode
        i = 0;
        do begin @(negedge core_clk); i++; end while ((ras_n | cas_n) !== 1'b0 && i < 400);
        if (i >= 400) n_mismatch++;
        do_req(OP_TEST_ENTRY, '0, '0, '0, rd);
        tm = 1'b1;
        wait_tm(1'b1);
        rd_chk(20'h00010);
        wr(20'h00020, 4'h1, MASK_ALL_WRITE);
        rd_chk(20'h00021);
        wr(20'h00030, 4'he, MASK_ALL_WRITE);
        rd_chk(20'h00030);
        do_req(OP_TEST_EXIT, '0, '0, '0, rd);
        tm = 1'b0;
        wait_tm(1'b0);
        rd_chk(20'h00031);
        rd_chk(20'h00020);
        // Long idle lets periodic refresh run before data is checked again
        repeat (300) @(posedge core_clk);
        foreach (addrs[k]) rd_chk(addrs[k]);
        tally_and_finish();
    end

    initial begin
        #200000;
        n_mismatch++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
